/* File: rtl/channel_unmute.sv */
// Automatic unmute sequencer for one PLL channel.
// Assumes sync, profile and lock inputs come from logic on ref_clk.
`timescale 1ns/10ps
module channel_unmute (
    input wire logic ref_clk, // Distribution clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic syncRequest, // Sync request held
    input wire logic profileActive, // Hitless or zero-delay profile active
    input wire logic phaseLocked, // Channel phase lock
    input wire logic freqLocked, // Channel frequency lock
    input wire logic [1:0] unmuteMode, // Automatic unmute condition
    input wire logic clearState, // Clear the automute state
    output logic autoMuted, // Automute state active
    output logic unmuteEvent // One-cycle unmute pulse
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SYNC = 3'b010,
        ST_WAIT = 3'b100
    } unmute_state_t;

    typedef struct packed {
        unmute_state_t state;
        logic autoMuted;
        logic unmuteEvent;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic condMet;

    always_comb begin
        s_d = s_q;
        s_d.unmuteEvent = 1'b0;
        case (unmuteMode)
            clk_drv_pkg::UNMUTE_PROFILE: condMet = profileActive;
            clk_drv_pkg::UNMUTE_PHASE_LOCK: condMet = phaseLocked;
            clk_drv_pkg::UNMUTE_FREQ_LOCK: condMet = freqLocked;
            default: condMet = 1'b1;
        endcase
        case (s_q.state)
            ST_IDLE: begin
                if (syncRequest) begin
                    s_d.state = ST_SYNC;
                end
            end
            ST_SYNC: begin
                if (!syncRequest) begin
                    if (unmuteMode == clk_drv_pkg::UNMUTE_IMMEDIATE) begin
                        s_d.state = ST_IDLE;
                        s_d.unmuteEvent = 1'b1;
                    end else begin
                        s_d.state = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                if (syncRequest) begin
                    s_d.state = ST_SYNC;
                end else if (condMet) begin
                    s_d.state = ST_IDLE;
                    s_d.unmuteEvent = 1'b1;
                end
            end
            default: s_d.state = ST_IDLE;
        endcase
        // A new sync request beats a clear arriving in the same cycle.
        if (clearState && !syncRequest) begin
            s_d.state = ST_IDLE;
            s_d.unmuteEvent = 1'b0;
        end
        s_d.autoMuted = (s_d.state != ST_IDLE);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_q <= '{state: ST_IDLE, autoMuted: 1'b0, unmuteEvent: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign autoMuted = s_q.autoMuted;
    assign unmuteEvent = s_q.unmuteEvent;

    sequence releasedInSync;
        s_q.state == ST_SYNC && !syncRequest && !clearState;
    endsequence

    a_release_unmute: assert property (@(posedge ref_clk) disable iff (!rst_n)
        releasedInSync and (unmuteMode == 2'h0) |=> unmuteEvent && !autoMuted)
        else $error("immediate mode did not unmute on release");
    a_lock_unmute: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_q.state == ST_WAIT && !syncRequest && !clearState && unmuteMode == 2'h2 && phaseLocked
        |=> unmuteEvent ##1 !unmuteEvent)
        else $error("phase lock did not unmute once");
    a_clear_state: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clearState && !syncRequest |=> !autoMuted && !unmuteEvent)
        else $error("automute clear ignored");
endmodule : channel_unmute

/* File: rtl/clk_drv_pkg.sv */
// Constants for the clock output driver control block: register offsets, field positions,
// reset values and mode encodings.
// Assumes an 8-bit register port with 16-bit addresses, two channels and five driver pairs.
package clk_drv_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int NUM_PAIRS = 5;
    localparam int NUM_CH = 2;
    localparam int CH0_PAIRS = 3;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [15:0] PAIR_CFG_ADDR [NUM_PAIRS] = '{16'h10d7, 16'h10d8, 16'h10d9, 16'h14d7, 16'h14d8};
    localparam logic [15:0] PAIR_MUTE_ADDR [NUM_PAIRS] = '{16'h2102, 16'h2103, 16'h2104, 16'h2202, 16'h2203};
    localparam logic [15:0] CH_UNMUTE_ADDR [NUM_CH] = '{16'h10dc, 16'h14dc};
    localparam logic [15:0] CH_MUTE_ADDR [NUM_CH] = '{16'h2101, 16'h2201};
    localparam logic [15:0] CH_CLEAR_ADDR [NUM_CH] = '{16'h2107, 16'h2207};

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int SRC_SINK_BIT = 0;
    localparam int CURRENT_LSB = 1;
    localparam int MODE_LSB = 3;
    localparam int UNMUTE_MODE_LSB = 0;
    localparam int MASK_LSB = 2;
    localparam int MUTE_ALL_BIT = 1;
    localparam int CH_RESET_BIT = 2;
    localparam int QDIV_RESET_BIT = 1;
    localparam int OUT_MUTE_LSB = 2;
    localparam int PAIR_RESET_BIT = 5;
    localparam int AUTOMUTE_CLEAR_BIT = 4;

    // ****************************************************************
    // Reset values and encodings
    // ****************************************************************
    localparam logic [4:0] CFG_RESET = 5'h00;
    localparam logic [7:0] UNMUTE_RESET = 8'h00;
    localparam logic [1:0] OUT_MUTE_RESET = 2'h3;
    localparam logic [1:0] MASK_WIDTH_CH1 = 2'h2;
    localparam logic [1:0] MODE_DIFF = 2'h0;
    localparam logic [1:0] MODE_SE_PHASE = 2'h1;
    localparam logic [1:0] MODE_SE_DUAL = 2'h2;
    localparam logic [1:0] UNMUTE_IMMEDIATE = 2'h0;
    localparam logic [1:0] UNMUTE_PROFILE = 2'h1;
    localparam logic [1:0] UNMUTE_PHASE_LOCK = 2'h2;
    localparam logic [1:0] UNMUTE_FREQ_LOCK = 2'h3;

endpackage : clk_drv_pkg

/* File: rtl/clock_output_driver_control.sv */
// Top of the clock output driver control: register port, mute and reset logic, pin outputs.
// Assumes divider, sync, profile and lock inputs are produced on ref_clk by neighbouring logic.
//
// What this block does
// - One source/sink bit steers both pair drivers.
// - Driver current on when divider high.
// - Differential mode uses true and inverted divider.
// - Channel reset bit resets all its pairs.
// - Pair reset bit resets only that pair.
// - Differential reset: positive low, negative high.
// - Single-ended reset: both pins low.
// - Mute-all bit mutes whole channel.
// - Output mutes default set; stop pins only.
// - Independent unmute condition field per channel.
// - Mode 0 release; mode 1 profile.
// - Mode 2 phase lock; mode 3 frequency lock.
// - Mask bits exclude outputs from auto unmute.
// - Clear bit or mode change clears automute.
// - Source/sink bit: 0 sink, 1 source.
// - Single-divider modes power down secondary divider.
`timescale 1ns/10ps
module clock_output_driver_control (
    input wire logic ref_clk, // Distribution clock, 20 MHz
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic [15:0] regAddr, // Register address
    input wire logic [7:0] regWrData, // Register write data
    input wire logic regWr, // Write strobe
    input wire logic regRd, // Read strobe
    output logic [7:0] regRdData, // Read data, cycle after strobe
    input wire logic ioUpdate, // Update operation pulse
    input wire logic [4:0] primaryDiv, // Primary divider per pair
    input wire logic [4:0] secondaryDiv, // Secondary divider per pair
    input wire logic [1:0] syncRequest, // Sync request per channel
    input wire logic [1:0] profileActive, // Hitless profile active per channel
    input wire logic [1:0] phaseLocked, // Phase lock per channel
    input wire logic [1:0] freqLocked, // Frequency lock per channel
    output logic [4:0] pairPositivePin, // Positive current source on
    output logic [4:0] pairNegativePin, // Negative current source on
    output logic [4:0] sourceSinkSelect, // 1 source, 0 sink, per pair
    output logic [9:0] driveCurrentField, // Drive current code, two bits per pair
    output logic [4:0] secondaryPowerDown, // Secondary divider off per pair
    output logic [4:0] dividerReset // Manual divider reset per pair
);
    localparam int NP = clk_drv_pkg::NUM_PAIRS;
    localparam int NC = clk_drv_pkg::NUM_CH;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [NP-1:0][4:0] cfg;
        logic [NC-1:0][7:0] unmute;
        logic [NC-1:0] muteAll;
        logic [NC-1:0] chReset;
        logic [NP-1:0][1:0] outMute;
        logic [NP-1:0] pairReset;
        logic [NP-1:0] qReset;
        logic [NC-1:0][1:0] appliedMode;
        logic [7:0] rdData;
        logic [NP-1:0] posPin;
        logic [NP-1:0] negPin;
        logic [NP-1:0] srcSink;
        logic [NP-1:0] secPd;
        logic [NP-1:0][1:0] current;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic [NC-1:0] clearState;
    logic [NC-1:0] autoMuted;
    logic [NC-1:0] unmuteEvent;
    logic [NP-1:0] drvPos;
    logic [NP-1:0] drvNeg;
    logic [NP-1:0] drvPd;
    logic [NP-1:0] effReset;
    logic [NP-1:0][1:0] effMute;
    logic [NP-1:0][1:0] outMask;

    function automatic int pairChannel(input int p);
        pairChannel = (p < clk_drv_pkg::CH0_PAIRS) ? 0 : 1;
    endfunction : pairChannel

    function automatic int pairLocal(input int p);
        pairLocal = (p < clk_drv_pkg::CH0_PAIRS) ? p : p - clk_drv_pkg::CH0_PAIRS;
    endfunction : pairLocal

    // ****************************************************************
    // Per-pair mask, mute and reset
    // ****************************************************************
    // Channel 1 has only two pairs, so its upper mask bits have no output behind them.
    always_comb begin
        for (int p = 0; p < NP; p++) begin
            for (int o = 0; o < 2; o++) begin
                outMask[p][o] = s_q.unmute[pairChannel(p)][clk_drv_pkg::MASK_LSB + 2 * pairLocal(p) + o];
                effMute[p][o] = s_q.muteAll[pairChannel(p)]
                    | s_q.outMute[p][o]
                    | (autoMuted[pairChannel(p)] & ~outMask[p][o]);
            end
            effReset[p] = s_q.chReset[pairChannel(p)] | s_q.pairReset[p];
        end
    end

    // ****************************************************************
    // Register port and next state
    // ****************************************************************
    always_comb begin
        s_d = s_q;
        s_d.rdData = 8'h00;
        clearState = '0;
        for (int c = 0; c < NC; c++) begin
            // The sequencer sees a changed condition field at once; an update that finds it changed clears the automute state.
            if (ioUpdate) begin
                s_d.appliedMode[c] = s_q.unmute[c][clk_drv_pkg::UNMUTE_MODE_LSB +: 2];
                if (s_q.unmute[c][clk_drv_pkg::UNMUTE_MODE_LSB +: 2] != s_q.appliedMode[c]) begin
                    clearState[c] = 1'b1;
                end
            end
            if (regWr && regAddr == clk_drv_pkg::CH_CLEAR_ADDR[c] && regWrData[clk_drv_pkg::AUTOMUTE_CLEAR_BIT]) begin
                clearState[c] = 1'b1;
            end
            if (regWr && regAddr == clk_drv_pkg::CH_UNMUTE_ADDR[c]) begin
                s_d.unmute[c] = (c == 0) ? regWrData : {2'h0, regWrData[5:0]};
            end
            if (regWr && regAddr == clk_drv_pkg::CH_MUTE_ADDR[c]) begin
                s_d.muteAll[c] = regWrData[clk_drv_pkg::MUTE_ALL_BIT];
                s_d.chReset[c] = regWrData[clk_drv_pkg::CH_RESET_BIT];
            end
            if (regRd && regAddr == clk_drv_pkg::CH_UNMUTE_ADDR[c]) begin
                s_d.rdData = s_q.unmute[c];
            end
            if (regRd && regAddr == clk_drv_pkg::CH_MUTE_ADDR[c]) begin
                s_d.rdData[clk_drv_pkg::MUTE_ALL_BIT] = s_q.muteAll[c];
                s_d.rdData[clk_drv_pkg::CH_RESET_BIT] = s_q.chReset[c];
            end
        end
        for (int p = 0; p < NP; p++) begin
            // The sequencer clears the manual mute of unmasked outputs when it unmutes.
            for (int o = 0; o < 2; o++) begin
                if (unmuteEvent[pairChannel(p)] && !outMask[p][o]) begin
                    s_d.outMute[p][o] = 1'b0;
                end
            end
            if (regWr && regAddr == clk_drv_pkg::PAIR_CFG_ADDR[p]) begin
                s_d.cfg[p] = regWrData[4:0];
            end
            // A software write lands after the sequencer so an explicit mute is never lost.
            if (regWr && regAddr == clk_drv_pkg::PAIR_MUTE_ADDR[p]) begin
                s_d.outMute[p] = regWrData[clk_drv_pkg::OUT_MUTE_LSB +: 2];
                s_d.pairReset[p] = regWrData[clk_drv_pkg::PAIR_RESET_BIT];
                s_d.qReset[p] = regWrData[clk_drv_pkg::QDIV_RESET_BIT];
            end
            if (regRd && regAddr == clk_drv_pkg::PAIR_CFG_ADDR[p]) begin
                s_d.rdData = {3'h0, s_q.cfg[p]};
            end
            if (regRd && regAddr == clk_drv_pkg::PAIR_MUTE_ADDR[p]) begin
                s_d.rdData[clk_drv_pkg::OUT_MUTE_LSB +: 2] = s_q.outMute[p];
                s_d.rdData[clk_drv_pkg::PAIR_RESET_BIT] = s_q.pairReset[p];
                s_d.rdData[clk_drv_pkg::QDIV_RESET_BIT] = s_q.qReset[p];
            end
            s_d.posPin[p] = drvPos[p];
            s_d.negPin[p] = drvNeg[p];
            s_d.secPd[p] = drvPd[p];
            s_d.srcSink[p] = s_q.cfg[p][clk_drv_pkg::SRC_SINK_BIT];
            s_d.current[p] = s_q.cfg[p][clk_drv_pkg::CURRENT_LSB +: 2];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_q <= '0;
            for (int p = 0; p < NP; p++) begin
                s_q.cfg[p] <= clk_drv_pkg::CFG_RESET;
                s_q.outMute[p] <= clk_drv_pkg::OUT_MUTE_RESET;
                s_q.negPin[p] <= 1'b0;
                s_q.secPd[p] <= 1'b1;
            end
            for (int c = 0; c < NC; c++) begin
                s_q.unmute[c] <= clk_drv_pkg::UNMUTE_RESET;
            end
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // Pair drivers
    // ****************************************************************
    genvar gp;
    generate
        for (gp = 0; gp < NP; gp++) begin : g_pair
            pair_driver u_drv (
                .primaryDiv(primaryDiv[gp]),
                .secondaryDiv(secondaryDiv[gp]),
                .routeMode(s_q.cfg[gp][clk_drv_pkg::MODE_LSB +: 2]),
                .pairReset(effReset[gp]),
                .mutePos(effMute[gp][0]),
                .muteNeg(effMute[gp][1]),
                .posOn(drvPos[gp]),
                .negOn(drvNeg[gp]),
                .secPowerDown(drvPd[gp])
            );

            a_diff_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
                effReset[gp] && s_q.cfg[gp][4:3] == 2'h0
                |=> !s_q.posPin[gp] && s_q.negPin[gp])
                else $error("differential reset level wrong");

            a_se_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
                effReset[gp] && s_q.cfg[gp][4:3] != 2'h0
                |=> !s_q.posPin[gp] && !s_q.negPin[gp])
                else $error("single-ended reset level wrong");

            // The channel bit is checked at the pins, so a broken pair driver is caught as well.
            a_chan_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
                s_q.chReset[pairChannel(gp)]
                |=> !s_q.posPin[gp] && s_q.negPin[gp] == ($past(s_q.cfg[gp][4:3]) == 2'h0))
                else $error("channel reset missed a pair");

            a_mute_all: assert property (@(posedge ref_clk) disable iff (!rst_n)
                s_q.muteAll[pairChannel(gp)] && !effReset[gp]
                |=> !s_q.posPin[gp] && !s_q.negPin[gp])
                else $error("mute all left a pin on");

            a_diff_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
                !effReset[gp] && effMute[gp] == 2'h0 && s_q.cfg[gp][4:3] == 2'h0
                |=> s_q.posPin[gp] == $past(primaryDiv[gp]) && s_q.negPin[gp] == !$past(primaryDiv[gp]))
                else $error("differential pins do not follow divider");

            a_dual_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
                !effReset[gp] && effMute[gp] == 2'h0 && s_q.cfg[gp][4:3] == 2'h2
                |=> s_q.posPin[gp] == $past(primaryDiv[gp]) && s_q.negPin[gp] == $past(secondaryDiv[gp])
                    && !s_q.secPd[gp])
                else $error("dual mode pins do not follow dividers");

            a_inphase_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
                !effReset[gp] && effMute[gp] == 2'h0 && s_q.cfg[gp][4:3] == 2'h1
                |=> s_q.posPin[gp] == $past(primaryDiv[gp]) && s_q.negPin[gp] == $past(primaryDiv[gp]))
                else $error("in-phase pins do not follow divider");

            a_sec_powerdown: assert property (@(posedge ref_clk) disable iff (!rst_n)
                s_q.cfg[gp][4:3] != 2'h2
                |=> s_q.secPd[gp])
                else $error("secondary divider left powered");

            a_src_sink: assert property (@(posedge ref_clk) disable iff (!rst_n)
                1'b1 |=> s_q.srcSink[gp] == $past(s_q.cfg[gp][0]))
                else $error("source sink select not applied");

            // A reset bit that stays set must keep the pair parked, not merely pass through it.
            sequence resetHeld;
                effReset[gp] ##1 effReset[gp];
            endsequence

            a_reset_holds: assert property (@(posedge ref_clk) disable iff (!rst_n)
                resetHeld |=> !s_q.posPin[gp])
                else $error("pair reset released while bit set");
        end
    endgenerate

    // ****************************************************************
    // Automatic unmute sequencers
    // ****************************************************************
    genvar gc;
    generate
        for (gc = 0; gc < NC; gc++) begin : g_ch
            channel_unmute u_unmute (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .syncRequest(syncRequest[gc]),
                .profileActive(profileActive[gc]),
                .phaseLocked(phaseLocked[gc]),
                .freqLocked(freqLocked[gc]),
                .unmuteMode(s_q.unmute[gc][clk_drv_pkg::UNMUTE_MODE_LSB +: 2]),
                .clearState(clearState[gc]),
                .autoMuted(autoMuted[gc]),
                .unmuteEvent(unmuteEvent[gc])
            );
        end
    endgenerate

    a_mute_default: assert property (@(posedge ref_clk)
        !rst_n |=> s_q.outMute == '1 && s_q.muteAll == 2'h0)
        else $error("mute defaults wrong after reset");

    // Both unmute checks watch channel 0, the channel whose sequencer the sync scenarios drive.
    a_mask_excludes: assert property (@(posedge ref_clk) disable iff (!rst_n)
        unmuteEvent[0] && outMask[1][0] && s_q.outMute[1][0]
            && !(regWr && regAddr == clk_drv_pkg::PAIR_MUTE_ADDR[1])
        |=> s_q.outMute[1][0])
        else $error("masked output was unmuted");

    a_unmute_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
        unmuteEvent[0] && !outMask[0][0] && !(regWr && regAddr == clk_drv_pkg::PAIR_MUTE_ADDR[0])
        |=> !s_q.outMute[0][0])
        else $error("unmasked output stayed muted");

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign regRdData = s_q.rdData;
    assign pairPositivePin = s_q.posPin;
    assign pairNegativePin = s_q.negPin;
    assign sourceSinkSelect = s_q.srcSink;
    assign driveCurrentField = s_q.current;
    assign secondaryPowerDown = s_q.secPd;
    assign dividerReset = s_q.qReset;

endmodule : clock_output_driver_control

/* File: rtl/pair_driver.sv */
// Pin switching for one driver pair: routes the dividers to the two current sources.
// Assumes the caller registers the outputs; this module is purely combinational.
`timescale 1ns/10ps
module pair_driver (
    input wire logic primaryDiv, // Primary divider output
    input wire logic secondaryDiv, // Secondary divider output
    input wire logic [1:0] routeMode, // Driver routing mode
    input wire logic pairReset, // Forced known state requested
    input wire logic mutePos, // Positive pin muted
    input wire logic muteNeg, // Negative pin muted
    output logic posOn, // Positive current source on
    output logic negOn, // Negative current source on
    output logic secPowerDown // Secondary divider powered down
);
    always_comb begin
        posOn = 1'b0;
        negOn = 1'b0;
        // A source is on exactly when the divider feeding it is high.
        case (routeMode)
            clk_drv_pkg::MODE_DIFF: begin
                posOn = primaryDiv;
                negOn = ~primaryDiv;
            end
            clk_drv_pkg::MODE_SE_PHASE: begin
                posOn = primaryDiv;
                negOn = primaryDiv;
            end
            clk_drv_pkg::MODE_SE_DUAL: begin
                posOn = primaryDiv;
                negOn = secondaryDiv;
            end
            default: begin
                posOn = 1'b0;
                negOn = 1'b0;
            end
        endcase
        if (mutePos) begin
            posOn = 1'b0;
        end
        if (muteNeg) begin
            negOn = 1'b0;
        end
        // Reset wins over mute so the receiver always sees a defined level.
        if (pairReset) begin
            posOn = 1'b0;
            negOn = (routeMode == clk_drv_pkg::MODE_DIFF);
        end
        secPowerDown = (routeMode != clk_drv_pkg::MODE_SE_DUAL);
    end
endmodule : pair_driver

/* File: testbench/clock_output_driver_control_bench.sv */
// Bench for the clock output driver control: register tasks, pin and mute checks.
// Assumes the design package is compiled first.
`timescale 1ns/10ps
module clock_output_driver_control_bench;
    logic ref_clk = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0, ioUpdate = 1'b0;
    logic [15:0] regAddr = 16'h0000;
    logic [7:0] regWrData = 8'h00, regRdData;
    logic [4:0] primaryDiv = 5'h00, secondaryDiv = 5'h00, pos, neg, src, spd, qrst;
    logic [1:0] syncRequest = 2'h0, profileActive = 2'h0, phaseLocked = 2'h0, freqLocked = 2'h0;
    logic [9:0] cur, sensed;
    int mismatches = 0, comparisons = 0, cycles = 0;
    clock_output_driver_control u_clock_output_driver_control (.ref_clk(ref_clk), .rst_n(rst_n),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .ioUpdate(ioUpdate), .primaryDiv(primaryDiv), .secondaryDiv(secondaryDiv), .syncRequest(syncRequest),
        .profileActive(profileActive), .phaseLocked(phaseLocked), .freqLocked(freqLocked), .pairPositivePin(pos),
        .pairNegativePin(neg), .sourceSinkSelect(src), .driveCurrentField(cur), .secondaryPowerDown(spd),
        .dividerReset(qrst));
    pin_receiver_model u_pin_receiver_model (.posPin(pos), .negPin(neg), .sensed(sensed));
    // ****************************************************************
    // Tasks
    // ****************************************************************
    initial forever #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            test_done();
        end
    end
    task automatic test_done();
        if (mismatches == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wait_n(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : wait_n
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 chk(regRdData, e);
    endtask : rd
    task automatic drv(input logic p, input logic s, input logic [1:0] e);
        @(posedge ref_clk);
        primaryDiv[0] <= p;
        secondaryDiv[0] <= s;
        wait_n(3);
        chk({6'h00, sensed[1:0]}, {6'h00, e});
    endtask : drv
    task automatic sync();
        @(posedge ref_clk);
        syncRequest[0] <= 1'b1;
        repeat (2) @(posedge ref_clk);
        syncRequest[0] <= 1'b0;
        wait_n(6);
    endtask : sync
    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(16'h10d7, 8'h00);
        rd(16'h2102, 8'h0c);
        rd(16'h10dc, 8'h00);
        rd(16'h3000, 8'h00);
        wr(16'h10dc, 8'h30);
        wr(16'h10d7, 8'h05);
        wr(16'h10d8, 8'h05);
        drv(1'b1, 1'b0, 2'b00);
        sync();
        rd(16'h2102, 8'h00);
        rd(16'h2103, 8'h0c);
        chk({3'h0, src}, 8'h03);
        chk(cur[7:0], 8'h0a);
        drv(1'b1, 1'b0, 2'b10);
        drv(1'b0, 1'b0, 2'b01);
        wr(16'h2102, 8'h20);
        drv(1'b1, 1'b0, 2'b01);
        wr(16'h10d7, 8'h09);
        drv(1'b1, 1'b0, 2'b00);
        wr(16'h2102, 8'h00);
        drv(1'b1, 1'b0, 2'b11);
        chk({3'h0, spd}, 8'h1f);
        wr(16'h10d7, 8'h11);
        drv(1'b1, 1'b0, 2'b10);
        drv(1'b0, 1'b1, 2'b01);
        chk({3'h0, spd}, 8'h1e);
        wr(16'h2101, 8'h04);
        drv(1'b1, 1'b1, 2'b00);
        wr(16'h2101, 8'h02);
        drv(1'b1, 1'b1, 2'b00);
        wr(16'h2101, 8'h00);
        drv(1'b1, 1'b1, 2'b11);
        wr(16'h2102, 8'h0c);
        wr(16'h10dc, 8'h02);
        @(posedge ref_clk) ioUpdate <= 1'b1;
        @(posedge ref_clk) ioUpdate <= 1'b0;
        sync();
        rd(16'h2102, 8'h0c);
        @(posedge ref_clk) phaseLocked[0] <= 1'b1;
        wait_n(4);
        rd(16'h2102, 8'h00);
        wr(16'h2102, 8'h0c);
        wr(16'h10dc, 8'h03);
        sync();
        wr(16'h2107, 8'h10);
        @(posedge ref_clk) freqLocked[0] <= 1'b1;
        wait_n(4);
        rd(16'h2102, 8'h0c);
        rd(16'h2107, 8'h00);
        wr(16'h10dc, 8'h01);
        sync();
        rd(16'h2102, 8'h0c);
        @(posedge ref_clk) profileActive[0] <= 1'b1;
        wait_n(4);
        rd(16'h2102, 8'h00);
        wr(16'h2102, 8'h22);
        wait_n(1);
        chk({3'h0, qrst}, 8'h01);
        rd(16'h2102, 8'h22);
        test_done();
    end
endmodule : clock_output_driver_control_bench

/* File: testbench/pin_receiver_model.sv */
// Receiver model for the five driver pairs: reports each pin as current on or off.
// Assumes the block drives registered pin levels on ref_clk.
`timescale 1ns/10ps
module pin_receiver_model (
    input wire logic [4:0] posPin, // Positive current source on
    input wire logic [4:0] negPin, // Negative current source on
    output logic [9:0] sensed // Per pair: positive, negative
);
    // ****************************************************************
    // Sensing
    // ****************************************************************
    // A terminated receiver only sees swing, so the analog load reduces to the on state.
    always_comb begin
        for (int p = 0; p < 5; p++) begin
            sensed[2*p +: 2] = {posPin[p], negPin[p]};
        end
    end
endmodule : pin_receiver_model
